// file: opcode_decode.sv
/*
 * Combinational decode of the held instruction and of the boundary-control
 * opcode. Assumes the caller registers the results.
 */
`timescale 1ns/1ps
`include "scan_decode_params.svh"

module opcode_decode (
    input wire logic [`IR_W-1:0] code_i,
    input wire logic [`RUN_OP_W-1:0] ctrl_op_i,
    output scan_decode_pkg::decode_type decode_o,
    output scan_decode_pkg::run_op_type run_op_o
);
    import scan_decode_pkg::*;

    function automatic decode_type mk(dr_sel_type s, mode_type m, capture_type c);
        decode_type d;
        d.dr_sel = s;
        d.mode = m;
        d.capture = c;
        d.cells_drive = (m == mode_test);
        d.pins_highz = (m == mode_mod_test);
        d.run_test = 1'b0;
        d.toggle_out = 1'b0;
        return d;
    endfunction

    function automatic decode_type dec(logic [`IR_W-1:0] c);
        decode_type d;
        case (c)
            `OP_EXT_BOUNDARY, `OP_INT_BOUNDARY: d = mk(dr_boundary, mode_test, cap_observe);
            `OP_IDENT: d = mk(dr_ident, mode_normal, cap_fixed);
            `OP_SAMPLE: d = mk(dr_boundary, mode_normal, cap_observe);
            `OP_HIGHZ: d = mk(dr_bypass, mode_mod_test, cap_fixed);
            `OP_CLAMP: d = mk(dr_bypass, mode_test, cap_fixed);
            `OP_RUN_TEST: begin
                d = mk(dr_bypass, mode_test, cap_fixed);
                d.run_test = 1'b1;
            end
            `OP_READ_NORMAL: d = mk(dr_boundary, mode_normal, cap_hold);
            `OP_READ_TEST: d = mk(dr_boundary, mode_test, cap_hold);
            `OP_SELF_CHECK: d = mk(dr_boundary, mode_normal, cap_invert);
            `OP_TOGGLE: begin
                d = mk(dr_bypass, mode_test, cap_fixed);
                d.toggle_out = 1'b1;
            end
            `OP_CTRL_NORMAL: d = mk(dr_control, mode_normal, cap_hold);
            `OP_CTRL_TEST: d = mk(dr_control, mode_test, cap_hold);
            // listed bypass codes and every undefined code fall here
            default: d = mk(dr_bypass, mode_normal, cap_fixed);
        endcase
        return d;
    endfunction

    wire run_hi_w = ctrl_op_i[2];
    wire [1:0] run_lo_w = ctrl_op_i[1:0];

    assign decode_o = dec(code_i);
    assign run_op_o = (run_lo_w == 2'b00) ? run_sample_toggle :
                      (run_lo_w == 2'b01) ? run_pattern :
                      (run_lo_w == 2'b10) ? run_signature :
                      run_hi_w ? run_sig_count : run_sig_pattern;

endmodule

// file: pin_sync.sv
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes its inputs are asynchronous pins; the first stage feeds only the second.
 */
`timescale 1ns/1ps

module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                meta_q[i] <= RST[i];
                sync_o[i] <= RST[i];
            end else if (ce_i) begin
                meta_q[i] <= async_i[i];
                sync_o[i] <= meta_q[i];
            end
        end
    end

endmodule

// file: scan_ctrl_model.sv
/*
 * Model of the external test controller on the four-wire port: walks the
 * state flags, shifts instructions and data, and reads tdo.
 * Assumes a 40 ns system clock; pin changes land on its falling edge and
 * TCK runs at 320 ns inside frames, parking high between them.
 */
`timescale 1ns/1ps

module scan_ctrl_model (
    input wire logic clk_i,
    input wire logic tdo_i,
    output scan_decode_pkg::tap_pins_type pins_o
);
    import scan_decode_pkg::*;

    localparam logic [6:0] ST_NONE = 7'h00;
    localparam logic [6:0] ST_TR = 7'h40;
    localparam logic [6:0] ST_CIR = 7'h20;
    localparam logic [6:0] ST_SIR = 7'h10;
    localparam logic [6:0] ST_UIR = 7'h08;
    localparam logic [6:0] ST_RTI = 7'h04;
    localparam logic [6:0] ST_CDR = 7'h02;
    localparam logic [6:0] ST_SDR = 7'h01;

    initial begin
        pins_o = '0;
        pins_o.tck = 1'b1;
        pins_o.tap.test_reset = 1'b1;
    end

    // flags move with the falling edge so they are steady around the rise
    task automatic cycle(input logic [6:0] st, input logic din, output logic dout);
        @(negedge clk_i);
        pins_o.tap = st;
        // an unused tdi flips, so a stale bit cannot pass for shifted data
        pins_o.tdi = (st == ST_SIR || st == ST_SDR) ? din : ~pins_o.tdi;
        pins_o.tck = 1'b0;
        #160;
        pins_o.tck = 1'b1;
        #150;
        dout = tdo_i;
    endtask

    // instructions go in lsb first; cap returns what came out
    task automatic shift_ir(input logic [7:0] code, output logic [7:0] cap);
        logic d;
        cycle(ST_NONE, 1'b0, d);
        cycle(ST_NONE, 1'b0, d);
        cycle(ST_CIR, 1'b0, d);
        for (int i = 0; i < 8; i++) begin
            cycle(ST_SIR, code[i], d);
            cap[i] = d;
        end
        cycle(ST_NONE, 1'b0, d);
    endtask

    task automatic update_ir();
        logic d;
        cycle(ST_UIR, 1'b0, d);
        cycle(ST_RTI, 1'b0, d);
    endtask

    task automatic scan_dr(input int n, input logic [7:0] din, output logic [7:0] dout);
        logic d;
        dout = '0;
        cycle(ST_NONE, 1'b0, d);
        cycle(ST_CDR, 1'b0, d);
        for (int i = 0; i < n; i++) begin
            cycle(ST_SDR, din[i], d);
            dout[i] = d;
        end
        cycle(ST_NONE, 1'b0, d);
        cycle(ST_NONE, 1'b0, d);
    endtask

    task automatic idle(input int n);
        logic d;
        repeat (n) cycle(ST_RTI, 1'b0, d);
    endtask

    task automatic test_reset();
        logic d;
        cycle(ST_TR, 1'b0, d);
    endtask
endmodule

// file: scan_decode_params.svh
/*
 * Constants of the scan instruction decoder: instruction width, opcodes,
 * reset and capture values.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SCAN_DECODE_PARAMS_SVH
`define SCAN_DECODE_PARAMS_SVH

`define IR_W 8
`define IR_RESET 8'h81
`define IR_CAPTURE 8'h81
`define RUN_OP_W 3
`define BYPASS_CAPTURE 1'b0

`define OP_EXT_BOUNDARY 8'h00
`define OP_IDENT 8'h81
`define OP_SAMPLE 8'h82
`define OP_INT_BOUNDARY 8'h03
`define OP_BYPASS_A 8'h84
`define OP_BYPASS_B 8'h05
`define OP_HIGHZ 8'h06
`define OP_CLAMP 8'h87
`define OP_BYPASS_C 8'h88
`define OP_RUN_TEST 8'h09
`define OP_READ_NORMAL 8'h0a
`define OP_READ_TEST 8'h8b
`define OP_SELF_CHECK 8'h0c
`define OP_TOGGLE 8'h8d
`define OP_CTRL_NORMAL 8'h8e
`define OP_CTRL_TEST 8'h0f

`endif

// file: scan_decode_pkg.sv
/*
 * Types of the scan instruction decoder: register selection, device mode,
 * capture behaviour, run-test operation and the grouped pin and decode buses.
 * Assumes scan_decode_params.svh is on the include path.
 */
`include "scan_decode_params.svh"

package scan_decode_pkg;

    typedef enum logic [1:0] {dr_boundary, dr_bypass, dr_ident, dr_control} dr_sel_type;

    typedef enum logic [1:0] {mode_normal, mode_test, mode_mod_test} mode_type;

    // cap_fixed: bypass loads 0, identification loads its code
    typedef enum logic [1:0] {cap_observe, cap_hold, cap_invert, cap_fixed} capture_type;

    typedef enum logic [2:0] {
        run_sample_toggle,
        run_pattern,
        run_signature,
        run_sig_pattern,
        run_sig_count
    } run_op_type;

    typedef struct packed {
        logic test_reset;
        logic capture_ir;
        logic shift_ir;
        logic update_ir;
        logic run_idle;
        logic capture_dr;
        logic shift_dr;
    } tap_state_type;

    typedef struct packed {
        logic tck;
        logic tdi;
        tap_state_type tap;
    } tap_pins_type;

    typedef struct packed {
        dr_sel_type dr_sel;
        mode_type mode;
        capture_type capture;
        logic cells_drive;
        logic pins_highz;
        logic run_test;
        logic toggle_out;
    } decode_type;

endpackage

// file: scan_instruction_decoder.sv
/*
 * Instruction register and decoder of the boundary-scan test port: holds the
 * 8-bit instruction, selects the data register and device mode, runs the
 * one-bit bypass register, drives TDO, and strobes run-test and toggle steps.
 * Assumes the port pins (TCK, TDI and the controller state flags) arrive
 * asynchronously and are sampled by clk_sys_i, TCK being much slower; the
 * other data registers sit on clk_sys_i and follow decode_o and the strobes.
 */
`timescale 1ns/1ps
`include "scan_decode_params.svh"

module scan_instruction_decoder (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input scan_decode_pkg::tap_pins_type pins_i,
    input wire logic bsr_so_i,
    input wire logic bcr_so_i,
    input wire logic idr_so_i,
    input wire logic [`RUN_OP_W-1:0] bcr_opcode_i,
    output logic [`IR_W-1:0] ir_o,
    output scan_decode_pkg::decode_type decode_o,
    output scan_decode_pkg::run_op_type run_op_o,
    output logic ir_parity_ok_o,
    output logic run_step_o,
    output logic toggle_step_o,
    output logic drive_step_o,
    output logic tdo_o,
    output logic tdo_oe_o
);
    import scan_decode_pkg::*;

    tap_pins_type pins_s;
    logic tck_prev_q;
    logic [`IR_W-1:0] ir_shift_q;
    logic [`IR_W-1:0] ir_hold_q;
    logic [`IR_W-1:0] ir_shift_d;
    logic [`IR_W-1:0] ir_hold_d;
    logic bypass_q;
    logic bypass_d;
    decode_type dec_w;
    run_op_type run_op_w;

    // pins cross into clk_sys_i before anything looks at them
    // tck resets to its parked high level, so leaving reset is never a clock edge
    pin_sync #(
        .W($bits(tap_pins_type)),
        .RST({1'b1, {($bits(tap_pins_type) - 1){1'b0}}})
    ) u_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .async_i(pins_i),
        .sync_o(pins_s)
    );

    // decode the held copy only, so shifting never disturbs the mode
    opcode_decode u_decode (
        .code_i(ir_hold_q),
        .ctrl_op_i(bcr_opcode_i),
        .decode_o(dec_w),
        .run_op_o(run_op_w)
    );

    // state flags move with TCK and pass the same two flops, so they stay
    // aligned with the synchronised clock and are stable at its edges
    wire tck_rise_w = ce_i & pins_s.tck & ~tck_prev_q;
    wire tck_fall_w = ce_i & ~pins_s.tck & tck_prev_q;
    wire st_reset_w = pins_s.tap.test_reset;
    wire st_cap_ir_w = pins_s.tap.capture_ir;
    wire st_shift_ir_w = pins_s.tap.shift_ir;
    wire st_upd_ir_w = pins_s.tap.update_ir;
    wire st_idle_w = pins_s.tap.run_idle;
    wire st_cap_dr_w = pins_s.tap.capture_dr;
    wire st_shift_dr_w = pins_s.tap.shift_dr;
    wire bypass_sel_w = (decode_o.dr_sel == dr_bypass);

    // test reset wins over every other state flag in both instruction registers; bypass ignores it
    assign ir_shift_d = st_reset_w ? `IR_RESET :
                        st_cap_ir_w ? `IR_CAPTURE :
                        st_shift_ir_w ? {pins_s.tdi, ir_shift_q[`IR_W-1:1]} :
                        ir_shift_q;
    assign ir_hold_d = st_reset_w ? `IR_RESET :
                       st_upd_ir_w ? ir_shift_q :
                       ir_hold_q;
    assign bypass_d = (st_cap_dr_w && bypass_sel_w) ? `BYPASS_CAPTURE :
                      (st_shift_dr_w && bypass_sel_w) ? pins_s.tdi :
                      bypass_q;

    wire dr_bit_w = (decode_o.dr_sel == dr_boundary) ? bsr_so_i :
                    (decode_o.dr_sel == dr_ident) ? idr_so_i :
                    (decode_o.dr_sel == dr_control) ? bcr_so_i :
                    bypass_q;
    wire tdo_d = st_shift_ir_w ? ir_shift_q[0] : dr_bit_w;
    wire tdo_oe_d = st_shift_ir_w | st_shift_dr_w;

    wire run_step_d = tck_rise_w & st_idle_w & decode_o.run_test;
    wire toggle_step_d = tck_rise_w & st_idle_w & (decode_o.toggle_out |
                         (decode_o.run_test && run_op_o == run_sample_toggle));
    wire drive_step_d = tck_fall_w & st_idle_w & (decode_o.toggle_out | decode_o.run_test);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tck_prev_q <= 1'b1;
        end else if (ce_i) begin
            tck_prev_q <= pins_s.tck;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ir_shift_q <= `IR_RESET;
            ir_hold_q <= `IR_RESET;
            bypass_q <= 1'b0;
        end else if (tck_rise_w) begin
            ir_shift_q <= ir_shift_d;
            ir_hold_q <= ir_hold_d;
            bypass_q <= bypass_d;
        end
    end

    // tdo changes on the falling TCK edge so the controller samples it stable
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tdo_o <= 1'b0;
            tdo_oe_o <= 1'b0;
        end else if (tck_fall_w) begin
            tdo_o <= tdo_d;
            tdo_oe_o <= tdo_oe_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ir_o <= `IR_RESET;
            decode_o <= '{dr_ident, mode_normal, cap_fixed, 1'b0, 1'b0, 1'b0, 1'b0};
            run_op_o <= run_sample_toggle;
            ir_parity_ok_o <= 1'b1;
        end else if (ce_i) begin
            ir_o <= ir_hold_q;
            decode_o <= dec_w;
            run_op_o <= run_op_w;
            ir_parity_ok_o <= ~^ir_hold_q;
        end
    end

    // one-cycle strobes; the cell logic acts on them at clk_sys_i rate
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_step_o <= 1'b0;
            toggle_step_o <= 1'b0;
            drive_step_o <= 1'b0;
        end else if (ce_i) begin
            run_step_o <= run_step_d;
            toggle_step_o <= toggle_step_d;
            drive_step_o <= drive_step_d;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence seq_reset_edge;
        tck_rise_w && st_reset_w;
    endsequence

    sequence seq_quiet_edge;
        ce_i && !(tck_rise_w && (st_reset_w || st_upd_ir_w));
    endsequence

    sequence seq_held(logic [`IR_W-1:0] code);
        ce_i && ir_hold_q == code;
    endsequence

    sequence seq_idle_rise;
        tck_rise_w && st_idle_w;
    endsequence

    ir_reset_value_a: assert property (seq_reset_edge |=> ir_hold_q == `IR_RESET
        ##1 !ce_i || decode_o.dr_sel == dr_ident)
        else $error("instruction not reset to identification");

    hold_stable_a: assert property (seq_quiet_edge |=> $stable(ir_hold_q))
        else $error("held instruction changed without update");

    boundary_test_a: assert property (seq_held(`OP_EXT_BOUNDARY) |=>
        decode_o.dr_sel == dr_boundary && decode_o.mode == mode_test
        && decode_o.capture == cap_observe && decode_o.cells_drive)
        else $error("boundary test decode wrong");

    undefined_bypass_a: assert property (ce_i && ir_hold_q[6:4] != 3'b000 |=>
        decode_o.dr_sel == dr_bypass && decode_o.mode == mode_normal)
        else $error("undefined code not bypass");

    bypass_capture_a: assert property (tck_rise_w && st_cap_dr_w && bypass_sel_w
        |=> !bypass_q)
        else $error("bypass did not capture zero");

    highz_decode_a: assert property (seq_held(`OP_HIGHZ) |=>
        decode_o.pins_highz && decode_o.mode == mode_mod_test && !decode_o.cells_drive)
        else $error("high impedance decode wrong");

    self_check_a: assert property (seq_held(`OP_SELF_CHECK) |=>
        decode_o.capture == cap_invert && decode_o.mode == mode_normal)
        else $error("self check decode wrong");

    run_step_a: assert property (seq_idle_rise ##0 decode_o.run_test |=> run_step_o
        ##1 (!run_step_o || !ce_i))
        else $error("run step strobe wrong");

    toggle_drive_a: assert property (tck_fall_w && st_idle_w && decode_o.toggle_out
        |=> drive_step_o && !toggle_step_o)
        else $error("toggle drive strobe missing");

    count_op_a: assert property (ce_i && bcr_opcode_i == 3'b111 |=> run_op_o == run_sig_count)
        else $error("count operation not selected");

    parity_flag_a: assert property (ce_i && $changed(ir_hold_q) |=>
        ir_parity_ok_o == ~^$past(ir_hold_q))
        else $error("parity flag wrong");

    sequence seq_update_edge;
        tck_rise_w && st_upd_ir_w && !st_reset_w;
    endsequence

    update_load_a: assert property (seq_update_edge |=>
        ir_hold_q == $past(ir_shift_q))
        else $error("update did not load shifted code");

    ir_follow_a: assert property (ce_i && $changed(ir_hold_q) |=>
        ir_o == $past(ir_hold_q))
        else $error("instruction output lags");

    sample_decode_a: assert property (seq_held(`OP_SAMPLE) |=>
        decode_o.dr_sel == dr_boundary && decode_o.mode == mode_normal
        && decode_o.capture == cap_observe && !decode_o.cells_drive)
        else $error("sample decode wrong");

    int_boundary_a: assert property (seq_held(`OP_INT_BOUNDARY) |=>
        decode_o.dr_sel == dr_boundary && decode_o.cells_drive && !decode_o.pins_highz)
        else $error("internal boundary decode wrong");

    bypass_codes_a: assert property (ce_i && (ir_hold_q == `OP_BYPASS_A
        || ir_hold_q == `OP_BYPASS_B || ir_hold_q == `OP_BYPASS_C) |=>
        decode_o.dr_sel == dr_bypass && decode_o.mode == mode_normal
        && decode_o.capture == cap_fixed)
        else $error("bypass code decode wrong");

    clamp_decode_a: assert property (seq_held(`OP_CLAMP) |=>
        decode_o.dr_sel == dr_bypass && decode_o.mode == mode_test && decode_o.cells_drive)
        else $error("clamp decode wrong");

    run_decode_a: assert property (seq_held(`OP_RUN_TEST) |=>
        decode_o.dr_sel == dr_bypass && decode_o.mode == mode_test
        && decode_o.run_test && !decode_o.toggle_out)
        else $error("run test decode wrong");

    read_hold_a: assert property (ce_i && (ir_hold_q == `OP_READ_NORMAL
        || ir_hold_q == `OP_READ_TEST) |=>
        decode_o.dr_sel == dr_boundary && decode_o.capture == cap_hold)
        else $error("boundary read decode wrong");

    ident_decode_a: assert property (seq_held(`OP_IDENT) |=>
        decode_o.dr_sel == dr_ident && decode_o.mode == mode_normal)
        else $error("identification decode wrong");

    toggle_decode_a: assert property (seq_held(`OP_TOGGLE) |=>
        decode_o.dr_sel == dr_bypass && decode_o.mode == mode_test
        && decode_o.toggle_out && !decode_o.run_test)
        else $error("toggle decode wrong");

    ctrl_scan_a: assert property (ce_i && (ir_hold_q == `OP_CTRL_NORMAL
        || ir_hold_q == `OP_CTRL_TEST) |=>
        decode_o.dr_sel == dr_control && decode_o.capture == cap_hold)
        else $error("control scan decode wrong");

    toggle_rise_a: assert property (seq_idle_rise ##0 decode_o.toggle_out |=>
        toggle_step_o && !run_step_o)
        else $error("toggle strobe missing");

    drive_run_a: assert property (tck_fall_w && st_idle_w && decode_o.run_test |=>
        drive_step_o)
        else $error("run drive strobe missing");

    no_step_a: assert property (ce_i && !decode_o.run_test && !decode_o.toggle_out |=>
        !run_step_o && !toggle_step_o && !drive_step_o)
        else $error("strobe outside run or toggle");

    sample_op_a: assert property (ce_i && bcr_opcode_i[1:0] == 2'b00 |=>
        run_op_o == run_sample_toggle)
        else $error("sample toggle not selected");

    pattern_op_a: assert property (ce_i && bcr_opcode_i[1:0] == 2'b01 |=>
        run_op_o == run_pattern)
        else $error("pattern not selected");

    signature_op_a: assert property (ce_i && bcr_opcode_i[1:0] == 2'b10 |=>
        run_op_o == run_signature)
        else $error("signature not selected");

endmodule

// file: scan_instruction_decoder_tb.sv
/*
 * Self-checking bench of the scan instruction decoder: loads every defined code and three others,
 * checks decode, parity, serial path and the run-test strobes.
 * Assumes scan_ctrl_model drives the port pins and the package is compiled.
 */
`timescale 1ns/1ps
`include "scan_decode_params.svh"

module scan_instruction_decoder_tb;
    import scan_decode_pkg::*;

    logic clk_sys_i, arst_n_i, ce_i, bsr_so_i, bcr_so_i, idr_so_i;
    logic [`RUN_OP_W-1:0] bcr_opcode_i;
    tap_pins_type pins;
    logic [`IR_W-1:0] ir_o;
    decode_type decode_o;
    run_op_type run_op_o;
    logic ir_parity_ok_o, run_step_o, toggle_step_o, drive_step_o, tdo_o, tdo_oe_o;
    int mismatches = 0;
    int n_tests = 0;
    int n_run = 0;
    int n_tog = 0;
    int n_drv = 0;
    logic [7:0] cur;
    // defined codes first, then odd parity and unlisted ones
    logic [7:0] codes [19] = '{8'h00, 8'h81, 8'h82, 8'h03, 8'h84, 8'h05, 8'h06, 8'h87,
        8'h88, 8'h09, 8'h0a, 8'h8b, 8'h0c, 8'h8d, 8'h8e, 8'h0f, 8'h01, 8'h11, 8'hff};

    scan_instruction_decoder i_scan_instruction_decoder (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .pins_i(pins),
        .bsr_so_i(bsr_so_i), .bcr_so_i(bcr_so_i), .idr_so_i(idr_so_i),
        .bcr_opcode_i(bcr_opcode_i), .ir_o(ir_o), .decode_o(decode_o), .run_op_o(run_op_o),
        .ir_parity_ok_o(ir_parity_ok_o), .run_step_o(run_step_o),
        .toggle_step_o(toggle_step_o), .drive_step_o(drive_step_o), .tdo_o(tdo_o),
        .tdo_oe_o(tdo_oe_o)
    );

    scan_ctrl_model i_scan_ctrl_model (.clk_i(clk_sys_i), .tdo_i(tdo_o), .pins_o(pins));

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (run_step_o === 1'b1) n_run++;
        if (toggle_step_o === 1'b1) n_tog++;
        if (drive_step_o === 1'b1) n_drv++;
    end

    function automatic decode_type exp_dec(input logic [7:0] c);
        decode_type e;
        e = '{dr_bypass, mode_normal, cap_fixed, 1'b0, 1'b0, 1'b0, 1'b0};
        case (c)
            `OP_EXT_BOUNDARY, `OP_INT_BOUNDARY: begin
                e.dr_sel = dr_boundary;
                e.mode = mode_test;
                e.capture = cap_observe;
            end
            `OP_IDENT: e.dr_sel = dr_ident;
            `OP_SAMPLE: begin
                e.dr_sel = dr_boundary;
                e.capture = cap_observe;
            end
            `OP_HIGHZ: begin
                e.mode = mode_mod_test;
                e.pins_highz = 1'b1;
            end
            `OP_CLAMP: e.mode = mode_test;
            `OP_RUN_TEST: begin
                e.mode = mode_test;
                e.run_test = 1'b1;
            end
            `OP_READ_NORMAL, `OP_READ_TEST, `OP_CTRL_NORMAL, `OP_CTRL_TEST: begin
                e.dr_sel = (c[2:0] == 3'h2 || c[2:0] == 3'h3) ? dr_boundary : dr_control;
                e.mode = c[0] ? mode_test : mode_normal;
                e.capture = cap_hold;
            end
            `OP_SELF_CHECK: begin
                e.dr_sel = dr_boundary;
                e.capture = cap_invert;
            end
            `OP_TOGGLE: begin
                e.mode = mode_test;
                e.toggle_out = 1'b1;
            end
            default: e.dr_sel = dr_bypass;
        endcase
        e.cells_drive = (e.mode == mode_test);
        return e;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic load(input logic [7:0] c);
        logic [7:0] cap;
        i_scan_ctrl_model.shift_ir(c, cap);
        check("ir capture", 32'(cap), 32'(`IR_CAPTURE));
        check("decode while shifting", 32'(decode_o), 32'(exp_dec(cur)));
        i_scan_ctrl_model.update_ir();
        cur = c;
    endtask

    task automatic t_reset();
        check("ir", 32'(ir_o), 32'(`IR_RESET));
        check("decode", 32'(decode_o), 32'(exp_dec(`OP_IDENT)));
        check("tdo enable", 32'(tdo_oe_o), 32'h0);
    endtask

    task automatic t_table();
        logic [7:0] so;
        decode_type e;
        for (int i = 0; i < 19; i++) begin
            e = exp_dec(codes[i]);
            load(codes[i]);
            check("ir", 32'(ir_o), 32'(codes[i]));
            check("decode", 32'(decode_o), 32'(e));
            check("parity", 32'(ir_parity_ok_o), 32'(~^codes[i]));
            @(posedge clk_sys_i);
            bsr_so_i <= (e.dr_sel == dr_boundary);
            bcr_so_i <= (e.dr_sel == dr_control);
            idr_so_i <= (e.dr_sel == dr_ident);
            i_scan_ctrl_model.scan_dr(2, 8'h03, so);
            check("tdo", 32'(so[1:0]), (e.dr_sel == dr_bypass) ? 32'h2 : 32'h3);
        end
    endtask

    task automatic t_resets();
        load(`OP_EXT_BOUNDARY);
        // a test reset presented while the enable is low must be lost
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        i_scan_ctrl_model.test_reset();
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        check("ir while frozen", 32'(ir_o), 32'(`OP_EXT_BOUNDARY));
        i_scan_ctrl_model.test_reset();
        repeat (8) @(posedge clk_sys_i);
        check("ir after test reset", 32'(ir_o), 32'(`IR_RESET));
        cur = `IR_RESET;
        load(`OP_EXT_BOUNDARY);
        @(posedge clk_sys_i);
        arst_n_i <= 1'b0;
        @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        cur = `IR_RESET;
        t_reset();
    endtask

    task automatic count(input int er, input int et, input int ed);
        int r, t, d;
        repeat (8) @(posedge clk_sys_i);
        r = n_run;
        t = n_tog;
        d = n_drv;
        i_scan_ctrl_model.idle(3);
        repeat (8) @(posedge clk_sys_i);
        check("run steps", 32'(n_run - r), 32'(er));
        check("toggle steps", 32'(n_tog - t), 32'(et));
        check("drive steps", 32'(n_drv - d), 32'(ed));
    endtask

    task automatic t_run();
        logic [7:0] so;
        run_op_type er;
        load(`OP_CTRL_NORMAL);
        i_scan_ctrl_model.scan_dr(3, 8'h07, so);
        load(`OP_RUN_TEST);
        for (int op = 0; op < 8; op++) begin
            case (op[1:0])
                2'd0: er = run_sample_toggle;
                2'd1: er = run_pattern;
                2'd2: er = run_signature;
                default: er = op[2] ? run_sig_count : run_sig_pattern;
            endcase
            @(posedge clk_sys_i);
            bcr_opcode_i <= op[2:0];
            repeat (3) @(posedge clk_sys_i);
            check("run op", 32'(run_op_o), 32'(er));
        end
        bcr_opcode_i <= 3'h0;
        count(3, 3, 3);
        bcr_opcode_i <= 3'h1;
        count(3, 0, 3);
        load(`OP_TOGGLE);
        count(0, 3, 3);
        load(`OP_BYPASS_A);
        count(0, 0, 0);
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        arst_n_i = 1'b0;
        ce_i = 1'b1;
        bsr_so_i = 1'b0;
        bcr_so_i = 1'b0;
        idr_so_i = 1'b0;
        bcr_opcode_i = '0;
        cur = `IR_RESET;
        repeat (10) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        t_reset();
        t_table();
        t_resets();
        t_run();
        test_done();
    end

    // the whole run needs well under half a millisecond
    initial begin
        #2000000;
        mismatches++;
        test_done();
    end
endmodule
